// >>> inc/rpc_regs.vh
// Notes on behaviour
// - Bytes go out low nibble first
// - Preamble is eight zero symbols
// - Two-symbol start delimiter follows the preamble
// - Length byte: seven bits, one reserved
// - Sixteen-bit check value ends the packet
// - Length counts payload bytes only
// - Triggers from command bits or timer pulses
// - Send ignored unless queue holds a packet
// - Receive stop ignored while packet in progress
// - Reset leaves mode machine idle
// - Load enters transmit, finish returns idle
// - Receive start enters receive, packet returns idle
// - Abort bit forces mode back to idle
// - Load beats simultaneous receive start
// - Transmit machine starts only on transmit mode
// - First state clears queue, requests first word
// - Wait for first word before loading
// - Separate fetch and store requests to DMA
// - One-cycle event pulses plus processor interrupt
// - Receive clock enable only when needed
// - Latch bus request at setup, report ready
// - Correlator uses build-time match threshold
// - Signal load done, then await send
// - Early idle passes through cleanup state
`ifndef RPC_REGS_VH
`define RPC_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RPC_OFF_COMMAND   8'h00
`define RPC_OFF_STATUS    8'h04
`define RPC_OFF_TX_WORD   8'h08
`define RPC_OFF_RX_WORD   8'h0C
`define RPC_OFF_TX_LEN    8'h10
`define RPC_OFF_TX_CHECK  8'h14

// ----------------------------------------------------------------
// Command bit positions
// ----------------------------------------------------------------
`define RPC_CMD_LOAD      0
`define RPC_CMD_SEND      1
`define RPC_CMD_RX_START  2
`define RPC_CMD_RX_STOP   3
`define RPC_CMD_ABORT     4
`define RPC_CMD_W         5

// ----------------------------------------------------------------
// Reset values and packet constants
// ----------------------------------------------------------------
`define RPC_RST_TX_LEN    7'h00
`define RPC_RST_TX_CHECK  16'h0000
`define RPC_PREAMBLE_BYTE 8'h00
`define RPC_PREAMBLE_LEN  3'h4
`define RPC_SFD_DEFAULT   8'hA7
`define RPC_SFD_INDEX     8'h04
`define RPC_CHECK_BYTES   8'h02

`endif

// >>> core/rpc_tx_queue.v
`timescale 1ns/100ps
`include "rpc_regs.vh"
module rpc_tx_queue (
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire       i_clear,
  input  wire       i_wr,
  input  wire [7:0] i_byte,
  input  wire       i_start,
  input  wire       i_link_clk,
  output reg        o_dout,
  output wire       o_loaded,
  output reg        o_sfd_done,
  output reg        o_done
);
  reg [7:0] mem [0:255];
  reg [7:0] wr_ptr_q;
  reg [7:0] rd_ptr_q;
  reg [2:0] bit_q;
  reg       send_q;
  reg       loaded_q;
  reg [2:0] sync_q;
  reg       lvl_q;
  wire      agree = (sync_q[1] == sync_q[2]);
  wire      rise  = agree & sync_q[2] & ~lvl_q;
  wire [7:0] cur  = mem[rd_ptr_q];

  assign o_loaded = loaded_q;

  always @(posedge i_clk) begin
    if (i_wr) begin
      mem[wr_ptr_q] <= i_byte;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_q <= 8'h00; rd_ptr_q <= 8'h00; bit_q <= 3'h0;
      send_q <= 1'b0; loaded_q <= 1'b0; sync_q <= 3'h0; lvl_q <= 1'b0;
      o_dout <= 1'b0; o_sfd_done <= 1'b0; o_done <= 1'b0;
    end else begin
      sync_q     <= {sync_q[1:0], i_link_clk};
      o_sfd_done <= 1'b0;
      o_done     <= 1'b0;
      if (agree) begin
        lvl_q <= sync_q[2];
      end
      if (i_clear) begin
        wr_ptr_q <= 8'h00; send_q <= 1'b0; loaded_q <= 1'b0; o_dout <= 1'b0;
      end else if (i_wr) begin
        wr_ptr_q <= wr_ptr_q + 8'h01;
        loaded_q <= 1'b1;
      end else if (i_start && loaded_q && !send_q) begin
        send_q <= 1'b1; rd_ptr_q <= 8'h00; bit_q <= 3'h0;
      end else if (send_q && rise) begin
        // LSB first puts the low nibble of each byte on the wire first
        o_dout <= cur[bit_q];
        bit_q  <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          rd_ptr_q <= rd_ptr_q + 8'h01;
          if (rd_ptr_q == `RPC_SFD_INDEX) begin
            o_sfd_done <= 1'b1;
          end
          if (rd_ptr_q + 8'h01 == wr_ptr_q) begin
            send_q <= 1'b0; loaded_q <= 1'b0; o_done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // rpc_tx_queue

// >>> core/rpc_rx_unit.v
`timescale 1ns/100ps
`include "rpc_regs.vh"
module rpc_rx_unit #(
  parameter [3:0] THRESHOLD = 4'd8,
  parameter [7:0] SFD_VALUE = `RPC_SFD_DEFAULT
) (
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire       i_clear,
  input  wire       i_enable,
  input  wire       i_link_clk,
  input  wire       i_din,
  output reg  [7:0] o_byte,
  output reg        o_byte_vld,
  output reg        o_detected,
  output reg        o_sfd_pulse
);
  reg [2:0] clk_sync_q;
  reg [2:0] din_sync_q;
  reg       clk_lvl_q;
  reg       din_lvl_q;
  reg [7:0] sr_q;
  reg [2:0] cnt_q;
  wire      clk_agree = (clk_sync_q[1] == clk_sync_q[2]);
  wire      rise      = clk_agree & clk_sync_q[2] & ~clk_lvl_q;
  wire [7:0] sr_n     = {din_lvl_q, sr_q[7:1]};

  function [3:0] ones8;
    input [7:0] v;
    integer k;
    begin
      ones8 = 4'h0;
      for (k = 0; k < 8; k = k + 1) begin
        ones8 = ones8 + {3'h0, v[k]};
      end
    end
  endfunction

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_sync_q <= 3'h0; din_sync_q <= 3'h0; clk_lvl_q <= 1'b0; din_lvl_q <= 1'b0;
      sr_q <= 8'h00; cnt_q <= 3'h0; o_byte <= 8'h00;
      o_byte_vld <= 1'b0; o_detected <= 1'b0; o_sfd_pulse <= 1'b0;
    end else begin
      clk_sync_q  <= {clk_sync_q[1:0], i_link_clk};
      din_sync_q  <= {din_sync_q[1:0], i_din};
      o_byte_vld  <= 1'b0;
      o_sfd_pulse <= 1'b0;
      if (clk_agree) begin
        clk_lvl_q <= clk_sync_q[2];
      end
      if (din_sync_q[1] == din_sync_q[2]) begin
        din_lvl_q <= din_sync_q[2];
      end
      if (i_clear) begin
        sr_q <= 8'h00; cnt_q <= 3'h0; o_detected <= 1'b0;
      end else if (i_enable && rise) begin
        sr_q <= sr_n;
        if (!o_detected) begin
          // Tolerant match: a few chip errors still find the frame
          if (ones8(~(sr_n ^ SFD_VALUE)) >= THRESHOLD) begin
            o_detected  <= 1'b1;
            o_sfd_pulse <= 1'b1;
            cnt_q       <= 3'h0;
          end
        end else begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            o_byte     <= sr_n;
            o_byte_vld <= 1'b1;
          end
        end
      end
    end
  end
endmodule // rpc_rx_unit

// >>> core/rpc_radio_packet_unit.v
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "rpc_regs.vh"
module rpc_radio_packet_unit #(
  parameter [3:0] CORRELATOR_THRESHOLD = 4'd8
) (
  input  wire        i_clk,
  input  wire        i_arst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  input  wire        i_tx_link_clk,
  output wire        o_tx_dout,
  input  wire        i_rx_link_clk,
  input  wire        i_rx_din,
  output wire        o_rx_clk_en,
  output wire        o_fetch_word_request,
  output wire        o_store_word_request,
  input  wire        i_load_timer,
  input  wire        i_send_timer,
  input  wire        i_rx_start_timer,
  input  wire        i_rx_stop_timer,
  output reg         o_load_done_pulse,
  output wire        o_tx_sfd_done_pulse,
  output reg         o_send_done_pulse,
  output wire        o_rx_sfd_done_pulse,
  output reg         o_rx_done_pulse,
  output reg         o_radio_cpu_interrupt
);
  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam [2:0] M_IDLE = 3'b001, M_TX = 3'b010, M_RX = 3'b100;
  localparam [10:0] T_SLEEP = 11'h001, T_INIT = 11'h002, T_INIT_WAIT = 11'h004,
                    T_PHY   = 11'h008, T_BYTE = 11'h010, T_DMA_WAIT  = 11'h020,
                    T_CRC0  = 11'h040, T_CRC1 = 11'h080, T_LOAD_DONE = 11'h100,
                    T_DRAIN = 11'h200;
  localparam [10:0] T_DONE = 11'h400;
  localparam [6:0] R_SLEEP = 7'h01, R_INIT = 7'h02, R_GET_LEN = 7'h04,
                   R_GET_BYTE = 7'h08, R_WAIT2 = 7'h10, R_DONE = 7'h20, R_SPARE = 7'h40;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  reg  [7:0]  addr_q;
  reg         wr_q;
  reg  [31:0] wdata_q;
  reg  [`RPC_CMD_W-1:0] cmd_q;
  reg  [6:0]  tx_len_q;
  reg  [15:0] tx_check_q;
  reg  [31:0] tx_word_q;
  reg  [31:0] rx_word_q;
  reg         fetch_req_q;
  reg         store_req_q;
  reg  [2:0]  mode_q;
  reg  [2:0]  mode_d;
  reg  [10:0] tx_q;
  reg  [10:0] tx_d;
  reg  [6:0]  rx_q;
  reg  [6:0]  rx_d;
  wire        tx_loaded;
  wire        tx_done;
  wire [7:0]  rx_byte;
  wire        rx_byte_vld;
  wire        rx_detected;

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = hit(a, `RPC_OFF_COMMAND) | hit(a, `RPC_OFF_STATUS) |
               hit(a, `RPC_OFF_TX_WORD) | hit(a, `RPC_OFF_RX_WORD) |
               hit(a, `RPC_OFF_TX_LEN)  | hit(a, `RPC_OFF_TX_CHECK);
    end
  endfunction

  wire setup  = i_psel & ~i_penable;
  wire access = i_psel & i_penable;
  wire wr_acc = access & wr_q;
  wire fetch_done = wr_acc & hit(addr_q, `RPC_OFF_TX_WORD);
  wire store_done = access & ~wr_q & hit(addr_q, `RPC_OFF_RX_WORD);

  // Zero wait states: request is latched at setup, so ready can stay high
  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~mapped(addr_q);

  wire [31:0] status_word = {23'h0, rx_detected, tx_loaded, store_req_q, fetch_req_q,
                             rx_q[6:1] != 6'h00, tx_q[10:1] != 10'h000, mode_q};

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_q <= 8'h00; wr_q <= 1'b0; wdata_q <= 32'h0000_0000; o_prdata <= 32'h0000_0000;
      cmd_q <= {`RPC_CMD_W{1'b0}}; tx_len_q <= `RPC_RST_TX_LEN;
      tx_check_q <= `RPC_RST_TX_CHECK; tx_word_q <= 32'h0000_0000;
    end else begin
      cmd_q <= {`RPC_CMD_W{1'b0}};
      if (setup) begin
        addr_q  <= i_paddr;
        wr_q    <= i_pwrite;
        wdata_q <= i_pwdata;
        if (hit(i_paddr, `RPC_OFF_STATUS)) begin
          o_prdata <= status_word;
        end else if (hit(i_paddr, `RPC_OFF_RX_WORD)) begin
          o_prdata <= rx_word_q;
        end else if (hit(i_paddr, `RPC_OFF_TX_LEN)) begin
          o_prdata <= {25'h0, tx_len_q};
        end else if (hit(i_paddr, `RPC_OFF_TX_CHECK)) begin
          o_prdata <= {16'h0, tx_check_q};
        end else begin
          o_prdata <= 32'h0000_0000;
        end
      end
      if (wr_acc) begin
        if (hit(addr_q, `RPC_OFF_COMMAND)) begin
          cmd_q <= wdata_q[`RPC_CMD_W-1:0];
        end
        if (hit(addr_q, `RPC_OFF_TX_WORD)) begin
          tx_word_q <= wdata_q;
        end
        if (hit(addr_q, `RPC_OFF_TX_LEN)) begin
          tx_len_q <= wdata_q[6:0];
        end
        if (hit(addr_q, `RPC_OFF_TX_CHECK)) begin
          tx_check_q <= wdata_q[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Triggers and mode select
  // ----------------------------------------------------------------
  wire trig_load  = cmd_q[`RPC_CMD_LOAD]     | i_load_timer;
  wire trig_send  = cmd_q[`RPC_CMD_SEND]     | i_send_timer;
  wire trig_start = cmd_q[`RPC_CMD_RX_START] | i_rx_start_timer;
  wire trig_stop  = cmd_q[`RPC_CMD_RX_STOP]  | i_rx_stop_timer;
  wire abort      = cmd_q[`RPC_CMD_ABORT];
  wire rx_busy    = (rx_q == R_GET_BYTE) | (rx_q == R_WAIT2) | rx_detected;

  always @* begin
    mode_d = mode_q;
    case (mode_q)
      M_IDLE: begin
        if (trig_load) begin
          mode_d = M_TX;
        end else if (trig_start) begin
          mode_d = M_RX;
        end
      end
      M_TX: begin
        if (abort || tx_q == T_DONE) begin
          mode_d = M_IDLE;
        end
      end
      M_RX: begin
        if (abort || rx_q == R_DONE || (trig_stop && !rx_busy)) begin
          mode_d = M_IDLE;
        end
      end
      default: mode_d = M_IDLE;
    endcase
  end

  assign o_rx_clk_en = mode_q[2];

  // ----------------------------------------------------------------
  // Transmit machine
  // ----------------------------------------------------------------
  reg  [2:0] phy_cnt_q;
  reg  [1:0] idx_q;
  reg  [7:0] tx_cnt_q;
  reg        q_wr;
  reg  [7:0] q_byte;
  wire       q_clear = (tx_q == T_INIT) | (tx_q == T_DONE);
  wire       q_start = (tx_q == T_LOAD_DONE) & trig_send & tx_loaded;
  wire [7:0] len8    = {1'b0, tx_len_q};

  always @* begin
    q_wr   = 1'b0;
    q_byte = 8'h00;
    case (tx_q)
      T_PHY: begin
        q_wr = 1'b1;
        if (phy_cnt_q < `RPC_PREAMBLE_LEN) begin
          q_byte = `RPC_PREAMBLE_BYTE;
        end else if (phy_cnt_q == `RPC_PREAMBLE_LEN) begin
          q_byte = `RPC_SFD_DEFAULT;
        end else begin
          q_byte = len8;
        end
      end
      T_BYTE: begin
        q_wr = 1'b1;
        case (idx_q)
          2'd0:    q_byte = tx_word_q[7:0];
          2'd1:    q_byte = tx_word_q[15:8];
          2'd2:    q_byte = tx_word_q[23:16];
          default: q_byte = tx_word_q[31:24];
        endcase
      end
      T_CRC0: begin
        q_wr = 1'b1;
        q_byte = tx_check_q[7:0];
      end
      T_CRC1: begin
        q_wr = 1'b1;
        q_byte = tx_check_q[15:8];
      end
      default: q_wr = 1'b0;
    endcase
  end

  always @* begin
    tx_d = tx_q;
    case (tx_q)
      T_SLEEP:     if (mode_q == M_TX) tx_d = T_INIT;
      T_INIT:      tx_d = T_INIT_WAIT;
      T_INIT_WAIT: if (!fetch_req_q) tx_d = T_PHY;
      T_PHY:       if (phy_cnt_q == 3'h5) tx_d = (len8 == 8'h00) ? T_CRC0 : T_BYTE;
      T_BYTE: begin
        if (tx_cnt_q + 8'h01 == len8) begin
          tx_d = T_CRC0;
        end else if (idx_q == 2'd3) begin
          tx_d = T_DMA_WAIT;
        end
      end
      T_DMA_WAIT:  if (!fetch_req_q) tx_d = T_BYTE;
      T_CRC0:      tx_d = T_CRC1;
      T_CRC1:      tx_d = T_LOAD_DONE;
      T_LOAD_DONE: if (q_start) tx_d = T_DRAIN;
      T_DRAIN:     if (tx_done) tx_d = T_DONE;
      T_DONE:      tx_d = T_SLEEP;
      default:     tx_d = T_DONE;
    endcase
    if (mode_q != M_TX && tx_q != T_SLEEP && tx_q != T_DONE) begin
      tx_d = T_DONE;
    end
  end

  // ----------------------------------------------------------------
  // Receive machine
  // ----------------------------------------------------------------
  reg  [1:0]  slot_q;
  reg  [7:0]  rx_cnt_q;
  reg  [7:0]  rx_total_q;
  reg  [31:0] asm_q;
  reg  [31:0] asm_n;
  wire        rx_take = (rx_q == R_GET_BYTE) & rx_byte_vld;
  wire        rx_last = (rx_cnt_q + 8'h01 == rx_total_q);
  wire        word_full = rx_take & (slot_q == 2'd3 || rx_last);

  // The length byte sits in the low byte of the first stored word
  always @* begin
    asm_n = asm_q;
    case (slot_q)
      2'd0:    asm_n[7:0]   = rx_byte;
      2'd1:    asm_n[15:8]  = rx_byte;
      2'd2:    asm_n[23:16] = rx_byte;
      default: asm_n[31:24] = rx_byte;
    endcase
  end

  always @* begin
    rx_d = rx_q;
    case (rx_q)
      R_SLEEP:    if (mode_q == M_RX) rx_d = R_INIT;
      R_INIT:     rx_d = R_GET_LEN;
      R_GET_LEN:  if (rx_byte_vld) rx_d = R_GET_BYTE;
      R_GET_BYTE: if (rx_take && rx_last) rx_d = R_WAIT2;
      R_WAIT2:    if (!store_req_q) rx_d = R_DONE;
      R_DONE:     rx_d = R_SLEEP;
      default:    rx_d = R_DONE;
    endcase
    if (mode_q != M_RX && rx_q != R_SLEEP && rx_q != R_DONE) begin
      rx_d = R_DONE;
    end
  end

  // ----------------------------------------------------------------
  // Sequential state
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= M_IDLE; tx_q <= T_SLEEP; rx_q <= R_SLEEP;
      phy_cnt_q <= 3'h0; idx_q <= 2'd0; tx_cnt_q <= 8'h00;
      fetch_req_q <= 1'b0; store_req_q <= 1'b0;
      slot_q <= 2'd0; rx_cnt_q <= 8'h00; rx_total_q <= 8'h00;
      asm_q <= 32'h0000_0000; rx_word_q <= 32'h0000_0000;
      o_load_done_pulse <= 1'b0; o_send_done_pulse <= 1'b0;
      o_rx_done_pulse <= 1'b0; o_radio_cpu_interrupt <= 1'b0;
    end else begin
      mode_q <= mode_d;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
      // Requesting the next word wins over a completion in the same cycle
      if (tx_q == T_INIT || (tx_q == T_BYTE && tx_d == T_DMA_WAIT)) begin
        fetch_req_q <= 1'b1;
      end else if (fetch_done || tx_q == T_DONE) begin
        fetch_req_q <= 1'b0;
      end
      if (tx_q == T_INIT) begin
        phy_cnt_q <= 3'h0; idx_q <= 2'd0; tx_cnt_q <= 8'h00;
      end else if (tx_q == T_PHY) begin
        phy_cnt_q <= phy_cnt_q + 3'h1;
      end else if (tx_q == T_BYTE) begin
        tx_cnt_q <= tx_cnt_q + 8'h01;
        idx_q    <= idx_q + 2'd1;
      end
      if (word_full) begin
        rx_word_q   <= asm_n;
        store_req_q <= 1'b1;
      end else if (store_done || rx_q == R_DONE) begin
        store_req_q <= 1'b0;
      end
      if (rx_q == R_INIT) begin
        slot_q <= 2'd0; asm_q <= 32'h0000_0000; rx_cnt_q <= 8'h00;
      end else if (rx_q == R_GET_LEN && rx_byte_vld) begin
        asm_q      <= {24'h0, rx_byte};
        slot_q     <= 2'd1;
        rx_total_q <= {1'b0, rx_byte[6:0]} + `RPC_CHECK_BYTES;
      end else if (rx_take) begin
        rx_cnt_q <= rx_cnt_q + 8'h01;
        slot_q   <= slot_q + 2'd1;
        asm_q    <= word_full ? 32'h0000_0000 : asm_n;
      end
      o_load_done_pulse <= (tx_d == T_LOAD_DONE) & (tx_q != T_LOAD_DONE);
      o_send_done_pulse <= (tx_q == T_DRAIN) & tx_done;
      o_rx_done_pulse   <= (rx_q == R_WAIT2) & (rx_d == R_DONE);
      o_radio_cpu_interrupt <= o_load_done_pulse | o_send_done_pulse | o_rx_done_pulse |
                               o_tx_sfd_done_pulse | o_rx_sfd_done_pulse;
    end
  end

  assign o_fetch_word_request = fetch_req_q;
  assign o_store_word_request = store_req_q;

  // ----------------------------------------------------------------
  // Serial ends
  // ----------------------------------------------------------------
  rpc_tx_queue u_tx (
    .i_clk      (i_clk),
    .i_arst_n   (i_arst_n),
    .i_clear    (q_clear),
    .i_wr       (q_wr),
    .i_byte     (q_byte),
    .i_start    (q_start),
    .i_link_clk (i_tx_link_clk),
    .o_dout     (o_tx_dout),
    .o_loaded   (tx_loaded),
    .o_sfd_done (o_tx_sfd_done_pulse),
    .o_done     (tx_done)
  );

  rpc_rx_unit #(
    .THRESHOLD (CORRELATOR_THRESHOLD)
  ) u_rx (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_clear     ((rx_q == R_INIT) | (rx_q == R_DONE)),
    .i_enable    ((rx_q == R_GET_LEN) | (rx_q == R_GET_BYTE) | (rx_q == R_WAIT2)),
    .i_link_clk  (i_rx_link_clk),
    .i_din       (i_rx_din),
    .o_byte      (rx_byte),
    .o_byte_vld  (rx_byte_vld),
    .o_detected  (rx_detected),
    .o_sfd_pulse (o_rx_sfd_done_pulse)
  );
endmodule // rpc_radio_packet_unit

// >>> bench/rpc_radio_packet_unit_properties.sv
`timescale 1ns/100ps
module rpc_props #(
  parameter [3:0] CORRELATOR_THRESHOLD = 4'd8
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_load_timer,
  input wire i_rx_start_timer,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_rx_clk_en,
  input wire o_fetch_word_request,
  input wire o_load_done_pulse,
  input wire o_tx_sfd_done_pulse,
  input wire o_send_done_pulse,
  input wire o_rx_sfd_done_pulse,
  input wire o_rx_done_pulse,
  input wire o_radio_cpu_interrupt
);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire ev = o_load_done_pulse | o_tx_sfd_done_pulse | o_send_done_pulse
          | o_rx_sfd_done_pulse | o_rx_done_pulse;
  sequence s_event; ev; endsequence
  sequence s_dual; i_load_timer && i_rx_start_timer && !o_rx_clk_en; endsequence
  a_ready_high: assert property (o_pready) else $error("ready low");
  a_err_access: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("error outside access");
  a_load_pulse: assert property (o_load_done_pulse |=> !o_load_done_pulse)
    else $error("load done too long");
  a_send_pulse: assert property (o_send_done_pulse |=> !o_send_done_pulse)
    else $error("send done too long");
  a_irq_follows: assert property (s_event |=> o_radio_cpu_interrupt)
    else $error("irq missing");
  a_irq_cause: assert property (o_radio_cpu_interrupt |-> $past(ev))
    else $error("irq without event");
  a_load_wins: assert property (s_dual |=> !o_rx_clk_en [*4])
    else $error("receive won over load");
  a_fetch_not_rx: assert property (o_fetch_word_request |-> !o_rx_clk_en)
    else $error("fetch in receive");
  a_rx_done_idle: assert property (o_rx_done_pulse |-> ##[0:2] !o_rx_clk_en)
    else $error("rx clock left on");
endmodule // rpc_props
bind rpc_radio_packet_unit rpc_props #(.CORRELATOR_THRESHOLD(CORRELATOR_THRESHOLD)) u_props (
  .i_clk, .i_arst_n, .i_psel, .i_penable, .i_load_timer, .i_rx_start_timer, .o_pready,
  .o_pslverr, .o_rx_clk_en, .o_fetch_word_request, .o_load_done_pulse, .o_tx_sfd_done_pulse,
  .o_send_done_pulse, .o_rx_sfd_done_pulse, .o_rx_done_pulse, .o_radio_cpu_interrupt);

// >>> bench/rpc_radio_model.sv
`timescale 1ns/100ps
module rpc_radio_model (
  input  wire logic i_tx_run,
  input  wire logic i_tx_dout,
  input  wire logic i_rx_go,
  output logic      o_tx_link_clk,
  output logic      o_rx_link_clk,
  output logic      o_rx_din
);
  logic [7:0] txq [$];
  logic [7:0] rxb [$];
  logic [7:0] sh;
  int         n;
  // ------------------------------------------------------------
  // Radio side
  // ------------------------------------------------------------
  initial begin
    o_tx_link_clk = 1'b0;
    o_rx_link_clk = 1'b0;
    o_rx_din = 1'b0;
    n = 0;
  end
  // Bit clock only runs inside a frame, as the radio does
  always begin
    wait (i_tx_run);
    #32 o_tx_link_clk = 1'b1;
    #32 o_tx_link_clk = 1'b0;
    sh = {i_tx_dout, sh[7:1]};
    n++;
    if (n % 8 == 0) txq.push_back(sh);
  end
  always @(posedge i_rx_go) begin
    foreach (rxb[i]) begin
      for (int b = 0; b < 8; b++) begin
        o_rx_din = rxb[i][b];
        #32 o_rx_link_clk = 1'b1;
        #32 o_rx_link_clk = 1'b0;
      end
    end
    // Released line flips so a stale bit is never taken as data
    o_rx_din = ~o_rx_din;
  end
endmodule // rpc_radio_model

// >>> bench/rpc_radio_packet_unit_tb.sv
`timescale 1ns/100ps
`include "rpc_regs.vh"
module rpc_radio_packet_unit_tb;
  logic        i_clk, i_arst_n, psel, penable, pwrite, er_q, tx_run, rx_go;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd_q;
  logic [3:0]  tmr;
  logic [7:0]  txe [12];
  wire  [31:0] prdata;
  wire         pready, pslverr, tx_clk, tx_dout, rx_clk, rx_din, rx_en;
  wire         fetch, store, ld_done, t_sfd, s_done, r_sfd, r_done, irq;
  int          failures, compares, cyc;

  rpc_radio_packet_unit DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_tx_link_clk(tx_clk),
    .o_tx_dout(tx_dout), .i_rx_link_clk(rx_clk), .i_rx_din(rx_din), .o_rx_clk_en(rx_en),
    .o_fetch_word_request(fetch), .o_store_word_request(store), .i_load_timer(tmr[0]),
    .i_send_timer(tmr[1]), .i_rx_start_timer(tmr[2]), .i_rx_stop_timer(tmr[3]),
    .o_load_done_pulse(ld_done), .o_tx_sfd_done_pulse(t_sfd), .o_send_done_pulse(s_done),
    .o_rx_sfd_done_pulse(r_sfd), .o_rx_done_pulse(r_done), .o_radio_cpu_interrupt(irq));
  rpc_radio_model u_radio (.i_tx_run(tx_run), .i_tx_dout(tx_dout), .i_rx_go(rx_go),
    .o_tx_link_clk(tx_clk), .o_rx_link_clk(rx_clk), .o_rx_din(rx_din));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd_q);
  endtask
  // Command bits take effect a cycle after the access edge, so let mode settle
  task automatic mode(input logic [2:0] m);
    repeat (2) @(posedge i_clk);
    apb(1'b0, `RPC_OFF_STATUS, 32'h0000_0000);
    chk("mode", {29'h0, m}, {29'h0, rd_q[2:0]});
  endtask
  task automatic trig(input logic [3:0] t);
    @(posedge i_clk);
    tmr <= t;
    @(posedge i_clk);
    tmr <= 4'h0;
  endtask
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    i_arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; tmr = 4'h0; tx_run = 1'b0; rx_go = 1'b0;
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rchk("status", `RPC_OFF_STATUS, 32'h0000_0001);
    rchk("unmapped", 8'h40, 32'h0000_0000);
    chk("slave error", 32'h0000_0001, {31'h0, er_q});
    trig(4'h2);
    mode(3'h1);
    $display("test idle done");
    apb(1'b1, `RPC_OFF_TX_LEN, 32'h0000_0004);
    apb(1'b1, `RPC_OFF_TX_CHECK, 32'h0000_1234);
    apb(1'b1, `RPC_OFF_COMMAND, 32'h0000_0001 << `RPC_CMD_LOAD);
    @(posedge i_clk iff fetch);
    mode(3'h2);
    apb(1'b1, `RPC_OFF_TX_WORD, 32'h4433_2211);
    @(posedge i_clk iff ld_done);
    trig(4'h2);
    tx_run <= 1'b1;
    @(posedge i_clk iff t_sfd);
    @(posedge i_clk iff s_done);
    tx_run <= 1'b0;
    // The radio takes the last bit half a link period after it is driven
    repeat (16) @(posedge i_clk);
    txe = '{8'h00, 8'h00, 8'h00, 8'h00, `RPC_SFD_DEFAULT, 8'h04,
            8'h11, 8'h22, 8'h33, 8'h44, 8'h34, 8'h12};
    chk("tx count", 32'd12, u_radio.txq.size());
    foreach (txe[i]) chk("tx byte", txe[i], u_radio.txq[i]);
    mode(3'h1);
    $display("test tx done");
    trig(4'h5);
    mode(3'h2);
    apb(1'b1, `RPC_OFF_COMMAND, 32'h0000_0001 << `RPC_CMD_ABORT);
    mode(3'h1);
    $display("test priority done");
    trig(4'h4);
    mode(3'h4);
    chk("rx clk en", 32'h0000_0001, {31'h0, rx_en});
    trig(4'h8);
    mode(3'h1);
    chk("rx clk en", 32'h0000_0000, {31'h0, rx_en});
    apb(1'b1, `RPC_OFF_COMMAND, 32'h0000_0001 << `RPC_CMD_RX_START);
    mode(3'h4);
    u_radio.rxb = '{8'h00, 8'h00, 8'h00, 8'h00, `RPC_SFD_DEFAULT, 8'h02,
                    8'h5A, 8'hC3, 8'h34, 8'h12};
    rx_go <= 1'b1;
    @(posedge i_clk iff r_sfd);
    trig(4'h8);
    mode(3'h4);
    @(posedge i_clk iff store);
    rchk("rx word", `RPC_OFF_RX_WORD, 32'h34C3_5A02);
    repeat (2) @(posedge i_clk);
    @(posedge i_clk iff store);
    rchk("rx word", `RPC_OFF_RX_WORD, 32'h0000_0012);
    @(posedge i_clk iff r_done);
    mode(3'h1);
    chk("rx clk en", 32'h0000_0000, {31'h0, rx_en});
    $display("test rx done");
    print_verdict();
  end
endmodule // rpc_radio_packet_unit_tb
